// ==== hw/acds_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module acds_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      count_ff;
    logic [AW:0]      nxt_count;
    logic             in_ready_ff;
    logic             push;
    logic             pop;

    assign push      = in_valid && in_ready_ff;
    assign pop       = out_valid && out_ready;
    assign out_valid = (count_ff != '0);
    assign out_data  = mem_ff[rd_ptr_ff];
    assign in_ready  = in_ready_ff;
    assign nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr_ff   <= '0;
            rd_ptr_ff   <= '0;
            count_ff    <= '0;
            in_ready_ff <= 1'b0;
        end else begin
            wr_ptr_ff   <= push ? AW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
            rd_ptr_ff   <= pop ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
            count_ff    <= nxt_count;
            in_ready_ff <= (nxt_count < (AW+1)'(DEPTH));
        end
    end
endmodule

// ==== hw/acds_pkg.sv ====
// Constants and carrier types for the coefficient decision sequencer.
package acds_pkg;
    localparam int VAL_W = 16;
    localparam int CTX_W = 8;
    localparam int IDX_W = 6;
    localparam int TBL_W = 2;
    localparam int FIFO_DEPTH = 16;

    localparam logic [IDX_W-1:0] FIRST_AC_INDEX  = 6'h01;
    localparam logic [IDX_W-1:0] last_scan_index = 6'h3f;

    localparam logic [CTX_W-1:0] DC_CLASS_ZERO      = 8'h00;
    localparam logic [CTX_W-1:0] DC_CLASS_SMALL_POS = 8'h04;
    localparam logic [CTX_W-1:0] DC_CLASS_SMALL_NEG = 8'h08;
    localparam logic [CTX_W-1:0] DC_CLASS_LARGE_POS = 8'h0c;
    localparam logic [CTX_W-1:0] DC_CLASS_LARGE_NEG = 8'h10;
    localparam logic [CTX_W-1:0] DC_SIGN_OFS        = 8'h01;
    localparam logic [CTX_W-1:0] DC_POS_OFS         = 8'h02;
    localparam logic [CTX_W-1:0] DC_NEG_OFS         = 8'h03;
    localparam logic [CTX_W-1:0] DC_X1_CTX          = 8'h14;
    localparam logic [CTX_W-1:0] AC_X1_CTX          = 8'hbe;
    localparam logic [CTX_W-1:0] AC_ZERO_OFS        = 8'h01;
    localparam logic [CTX_W-1:0] AC_SIGN_OFS        = 8'h02;
    localparam logic [CTX_W-1:0] AC_POS_PER_INDEX   = 8'h03;
    localparam logic [CTX_W-1:0] MAG_BITS_OFS       = 8'h0e;
    localparam logic [CTX_W-1:0] CTX_STEP           = 8'h01;

    localparam logic [VAL_W:0]   FIRST_BOUND = 17'h00002;
    localparam logic [VAL_W-1:0] ONE_VAL     = 16'h0001;

    typedef enum logic [1:0] {
        ACDS_WORD_COEF  = 2'h0,
        ACDS_WORD_START = 2'h1,
        ACDS_WORD_END   = 2'h2
    } acds_word_kind_t;

    typedef enum logic [1:0] {
        ACDS_OP_DECIDE = 2'h0,
        ACDS_OP_INIT   = 2'h1,
        ACDS_OP_FLUSH  = 2'h2
    } acds_op_t;

    typedef struct packed {
        acds_word_kind_t   kind;
        logic [TBL_W-1:0]  dc_tbl;
        logic [TBL_W-1:0]  ac_tbl;
        logic [IDX_W-1:0]  last_nonzero;
        logic [VAL_W-1:0]  value;
    } acds_coef_t;

    typedef struct packed {
        acds_op_t          op;
        logic              bit_val;
        logic              is_ac;
        logic [TBL_W-1:0]  tbl;
        logic [CTX_W-1:0]  ctx;
    } acds_decision_t;
endpackage

// ==== hw/acds_sequencer.sv ====
// Coefficient-to-binary-decision sequencer feeding an arithmetic coder.
`timescale 1ns/1ps
module acds_sequencer
    import acds_pkg::*;
(
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    input  wire acds_coef_t       coef_data,
    input  wire logic             coef_valid,
    output logic                  coef_ready,
    input  wire logic [3:0]       cond_lower,
    input  wire logic [3:0]       cond_upper,
    output acds_decision_t        dec_data,
    output logic                  dec_valid,
    input  wire logic             dec_ready
);
    typedef enum logic [2:0] {
        ST_FETCH,
        ST_DC_ZERO,
        ST_AC_ZERO,
        ST_SIGN,
        ST_CAT_FIRST,
        ST_CAT_LOOP,
        ST_BITS,
        ST_EOB
    } acds_state_t;

    acds_coef_t       fifo_data;
    logic             fifo_valid;
    logic             fifo_pop;

    acds_state_t      state_ff, nxt_state;
    logic [IDX_W-1:0] k_ff, nxt_k;
    logic [VAL_W-1:0] val_ff, nxt_val;
    logic [TBL_W-1:0] dc_tbl_ff, nxt_dc_tbl;
    logic [TBL_W-1:0] ac_tbl_ff, nxt_ac_tbl;
    logic [IDX_W-1:0] last_nz_ff, nxt_last_nz;
    logic [CTX_W-1:0] s0_ff, nxt_s0;
    logic [CTX_W-1:0] ctx_ff, nxt_ctx;
    logic [VAL_W:0]   m_ff, nxt_m;
    logic             eob_ff, nxt_eob;
    logic             dec_valid_ff;
    acds_decision_t   dec_ff;

    logic             emit;
    acds_op_t         e_op;
    logic             e_bit;
    logic [CTX_W-1:0] e_ctx;
    logic             da_clear;
    logic             da_we;

    // Coefficients are buffered ahead of the decision tree.
    acds_fifo #(
        .WIDTH ($bits(acds_coef_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .in_data   (coef_data),
        .in_valid  (coef_valid),
        .in_ready  (coef_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    // Output slot is free when empty or being taken this cycle.
    wire out_free = !dec_valid_ff || dec_ready;
    wire is_ac    = (k_ff != '0);
    wire val_nz   = (val_ff != '0);
    wire val_neg  = val_ff[VAL_W-1];

    // Reduced magnitude, shared by DC and AC paths.
    wire [VAL_W-1:0] abs_val = val_neg ? VAL_W'(-val_ff) : val_ff;
    wire [VAL_W-1:0] reduced_magnitude = abs_val - ONE_VAL;
    wire [VAL_W:0]   sz_ext = {1'b0, reduced_magnitude};

    // AC contexts step by three per zig-zag position.
    wire [CTX_W-1:0] k_ctx = CTX_W'(k_ff);
    wire [CTX_W-1:0] end_block_ctx = CTX_W'(k_ctx * AC_POS_PER_INDEX) - AC_POS_PER_INDEX;
    wire [CTX_W-1:0] ac_zero_ctx   = end_block_ctx + AC_ZERO_OFS;
    wire [CTX_W-1:0] ac_sign_ctx   = end_block_ctx + AC_SIGN_OFS;

    // Previous DC difference per DC table, classified for the zero context.
    logic [VAL_W-1:0] da_ff [4];
    wire [VAL_W-1:0]  previous_block_difference = da_ff[dc_tbl_ff];
    wire              da_neg = previous_block_difference[VAL_W-1];
    wire [VAL_W-1:0]  da_abs = da_neg ? VAL_W'(-previous_block_difference)
                                      : previous_block_difference;
    wire [VAL_W:0]    low_bound = (cond_lower == 4'h0) ? '0
                                  : (VAL_W+1)'(1) << (cond_lower - 4'h1);
    wire [VAL_W:0]    up_bound  = (VAL_W+1)'(1) << cond_upper;
    wire              da_zero   = ({1'b0, da_abs} <= low_bound);
    wire              da_small  = ({1'b0, da_abs} <= up_bound);
    wire [CTX_W-1:0]  dc_class_context_select =
        da_zero  ? DC_CLASS_ZERO :
        da_small ? (da_neg ? DC_CLASS_SMALL_NEG : DC_CLASS_SMALL_POS) :
                   (da_neg ? DC_CLASS_LARGE_NEG : DC_CLASS_LARGE_POS);

    // Sign-stage contexts for both models; the tree itself is common.
    wire [CTX_W-1:0] sign_ctx          = is_ac ? ac_sign_ctx : s0_ff + DC_SIGN_OFS;
    wire [CTX_W-1:0] positive_sign_ctx = is_ac ? ac_sign_ctx : s0_ff + DC_POS_OFS;
    wire [CTX_W-1:0] negative_sign_ctx = is_ac ? ac_sign_ctx : s0_ff + DC_NEG_OFS;
    wire [CTX_W-1:0] x1_ctx            = is_ac ? AC_X1_CTX : DC_X1_CTX;

    wire             at_last   = (k_ff == last_scan_index);
    wire             cat_more  = (sz_ext >= m_ff);
    wire [VAL_W:0]   first_bit = m_ff >> 2;
    wire [VAL_W:0]   m_shift   = m_ff >> 1;
    wire             bit_sel   = ((sz_ext & m_ff) != '0);

    always_comb begin
        nxt_state   = state_ff;
        nxt_k       = k_ff;
        nxt_val     = val_ff;
        nxt_dc_tbl  = dc_tbl_ff;
        nxt_ac_tbl  = ac_tbl_ff;
        nxt_last_nz = last_nz_ff;
        nxt_s0      = s0_ff;
        nxt_ctx     = ctx_ff;
        nxt_m       = m_ff;
        nxt_eob     = eob_ff;
        emit        = 1'b0;
        e_op        = ACDS_OP_DECIDE;
        e_bit       = 1'b0;
        e_ctx       = ctx_ff;
        da_clear    = 1'b0;
        da_we       = 1'b0;
        fifo_pop    = 1'b0;
        unique case (state_ff)
            ST_FETCH: begin
                fifo_pop = fifo_valid && out_free;
                if (fifo_pop) begin
                    unique case (fifo_data.kind)
                        ACDS_WORD_START: begin
                            emit     = 1'b1;
                            e_op     = ACDS_OP_INIT;
                            da_clear = 1'b1;
                            nxt_k    = '0;
                            nxt_eob  = 1'b0;
                        end
                        ACDS_WORD_END: begin
                            emit    = 1'b1;
                            e_op    = ACDS_OP_FLUSH;
                            nxt_k   = '0;
                            nxt_eob = 1'b0;
                        end
                        default: begin
                            if (k_ff == '0) begin
                                nxt_val     = fifo_data.value;
                                nxt_dc_tbl  = fifo_data.dc_tbl;
                                nxt_ac_tbl  = fifo_data.ac_tbl;
                                nxt_last_nz = fifo_data.last_nonzero;
                                nxt_state   = ST_DC_ZERO;
                            end else if (eob_ff) begin
                                // Remaining zero coefficients are swallowed silently.
                                nxt_k = at_last ? '0 : k_ff + 1'b1;
                                if (at_last) begin
                                    nxt_eob = 1'b0;
                                end
                            end else begin
                                nxt_val   = fifo_data.value;
                                nxt_state = ST_AC_ZERO;
                            end
                        end
                    endcase
                end
            end
            ST_DC_ZERO: begin
                if (out_free) begin
                    emit   = 1'b1;
                    e_bit  = val_nz;
                    e_ctx  = dc_class_context_select;
                    nxt_s0 = dc_class_context_select;
                    if (val_nz) begin
                        nxt_state = ST_SIGN;
                    end else begin
                        da_we     = 1'b1;
                        nxt_k     = FIRST_AC_INDEX;
                        nxt_state = ST_EOB;
                    end
                end
            end
            ST_AC_ZERO: begin
                if (out_free) begin
                    emit  = 1'b1;
                    e_bit = val_nz;
                    e_ctx = ac_zero_ctx;
                    if (val_nz) begin
                        nxt_state = ST_SIGN;
                    end else begin
                        nxt_k     = at_last ? '0 : k_ff + 1'b1;
                        nxt_state = ST_FETCH;
                    end
                end
            end
            ST_SIGN: begin
                if (out_free) begin
                    emit      = 1'b1;
                    e_bit     = val_neg;
                    e_ctx     = sign_ctx;
                    nxt_ctx   = val_neg ? negative_sign_ctx : positive_sign_ctx;
                    nxt_state = ST_CAT_FIRST;
                end
            end
            ST_CAT_FIRST: begin
                if (out_free) begin
                    emit  = 1'b1;
                    e_bit = (reduced_magnitude != '0);
                    if (reduced_magnitude != '0) begin
                        nxt_ctx   = x1_ctx;
                        nxt_m     = FIRST_BOUND;
                        nxt_state = ST_CAT_LOOP;
                    end else begin
                        nxt_state = ST_EOB;
                    end
                end
            end
            ST_CAT_LOOP: begin
                if (out_free) begin
                    emit  = 1'b1;
                    e_bit = cat_more;
                    if (cat_more) begin
                        nxt_m   = m_ff << 1;
                        nxt_ctx = ctx_ff + CTX_STEP;
                    end else begin
                        nxt_m     = first_bit;
                        nxt_ctx   = ctx_ff + MAG_BITS_OFS;
                        nxt_state = (first_bit == '0) ? ST_EOB : ST_BITS;
                    end
                end
            end
            ST_BITS: begin
                if (out_free) begin
                    emit  = 1'b1;
                    e_bit = bit_sel;
                    nxt_m = m_shift;
                    if (m_shift == '0) begin
                        nxt_state = ST_EOB;
                    end
                end
            end
            ST_EOB: begin
                if (out_free) begin
                    emit      = 1'b1;
                    e_bit     = (k_ff > last_nz_ff);
                    e_ctx     = end_block_ctx;
                    nxt_eob   = (k_ff > last_nz_ff);
                    nxt_state = ST_FETCH;
                end
            end
        endcase
        // Value coding finished: close out the DC or AC step.
        if (emit && (nxt_state == ST_EOB) && (state_ff != ST_EOB)
                && (state_ff != ST_DC_ZERO)) begin
            if (!is_ac) begin
                da_we = 1'b1;
                nxt_k = FIRST_AC_INDEX;
            end else if (at_last) begin
                nxt_k     = '0;
                nxt_state = ST_FETCH;
            end else begin
                nxt_k = k_ff + 1'b1;
            end
        end
    end

    // Per-table previous difference, cleared at every interval start.
    genvar t;
    generate
        for (t = 0; t < 4; t++) begin : g_da
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    da_ff[t] <= '0;
                end else if (da_clear) begin
                    da_ff[t] <= '0;
                end else if (da_we && (dc_tbl_ff == TBL_W'(t))) begin
                    da_ff[t] <= val_ff;
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_ff   <= ST_FETCH;
            k_ff       <= '0;
            val_ff     <= '0;
            dc_tbl_ff  <= '0;
            ac_tbl_ff  <= '0;
            last_nz_ff <= '0;
            s0_ff      <= '0;
            ctx_ff     <= '0;
            m_ff       <= '0;
            eob_ff     <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            k_ff       <= nxt_k;
            val_ff     <= nxt_val;
            dc_tbl_ff  <= nxt_dc_tbl;
            ac_tbl_ff  <= nxt_ac_tbl;
            last_nz_ff <= nxt_last_nz;
            s0_ff      <= nxt_s0;
            ctx_ff     <= nxt_ctx;
            m_ff       <= nxt_m;
            eob_ff     <= nxt_eob;
        end
    end

    // Decision register holds its word until the coder takes it.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            dec_valid_ff <= 1'b0;
            dec_ff       <= '0;
        end else if (out_free) begin
            dec_valid_ff <= emit;
            if (emit) begin
                dec_ff <= '{op: e_op, bit_val: e_bit, is_ac: is_ac,
                            tbl: is_ac ? ac_tbl_ff : dc_tbl_ff, ctx: e_ctx};
            end
        end
    end

    assign dec_valid = dec_valid_ff;
    assign dec_data  = dec_ff;
endmodule

// ==== sim/acds_coder_model.sv ====
// Behavioural coder stand-in that takes decisions promptly or with stalls.
`timescale 1ns/1ps
module acds_coder_model
    import acds_pkg::*;
(
    input  wire logic           sys_clk,
    input  wire logic           rstn,
    input  wire acds_decision_t dec_data,
    input  wire logic           dec_valid,
    input  wire logic [1:0]     mode,
    output logic                dec_ready,
    output logic                take,
    output acds_decision_t      taken
);
    logic [1:0] cnt_ff;
    // Mode 0 takes every cycle, mode 1 one cycle in four, mode 2 holds off.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_ff    <= 2'h0;
            dec_ready <= 1'b0;
        end else begin
            cnt_ff    <= cnt_ff + 2'h1;
            dec_ready <= mode == 2'h0 || (mode == 2'h1 && cnt_ff == 2'h2);
        end
    end
    assign take  = dec_valid && dec_ready;
    assign taken = dec_data;
endmodule

// ==== sim/acds_seq_asserts.sv ====
// Port assertions for the coefficient decision sequencer.
`timescale 1ns/1ps
module acds_seq_asserts
    import acds_pkg::*;
(
    input wire logic           sys_clk,
    input wire logic           rstn,
    input wire acds_coef_t     coef_data,
    input wire logic           coef_valid,
    input wire logic           coef_ready,
    input wire logic [3:0]     cond_lower,
    input wire logic [3:0]     cond_upper,
    input wire acds_decision_t dec_data,
    input wire logic           dec_valid,
    input wire logic           dec_ready
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    acds_decision_t p_ff;
    logic           pv_ff;
    logic           open_ff;
    wire            take = dec_valid && dec_ready;
    wire            nd   = dec_valid && dec_data.op == ACDS_OP_DECIDE;
    wire            pd   = pv_ff && p_ff.op == ACDS_OP_DECIDE;
    wire            pdc  = pd && !p_ff.is_ac && p_ff.ctx < 8'h14;
    wire            pac  = pd && p_ff.is_ac && p_ff.ctx < 8'hbd;
    wire [7:0]      pm3  = p_ff.ctx % 8'h03;
    wire [7:0]      pc   = p_ff.ctx;
    wire            pb   = p_ff.bit_val;
    // The last taken decision tells which decision must come next.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            p_ff    <= '0;
            pv_ff   <= 1'b0;
            open_ff <= 1'b0;
        end else if (take) begin
            p_ff    <= dec_data;
            pv_ff   <= 1'b1;
            open_ff <= dec_data.op != ACDS_OP_FLUSH;
        end
    end
    hold_stable_a: assert property (dec_valid && !dec_ready |=> dec_valid && $stable(dec_data))
        else $error("decision changed while stalled");
    init_first_a: assert property (dec_valid && dec_data.op != ACDS_OP_INIT |-> open_ff)
        else $error("decision or flush without coder start");
    dc_zero_end_a: assert property (nd && pdc && pc[1:0] == 2'h0 && !pb |->
        dec_data.is_ac && dec_data.ctx == 8'h00) else $error("zero difference not followed by eob");
    dc_zero_sign_a: assert property (nd && pdc && pc[1:0] == 2'h0 && pb |->
        !dec_data.is_ac && dec_data.ctx == pc + 8'h01) else $error("dc sign context wrong");
    dc_sign_mag_a: assert property (nd && pdc && pc[1:0] == 2'h1 |->
        !dec_data.is_ac && dec_data.ctx == pc + 8'h01 + pb) else $error("dc magnitude context");
    eob_stop_a: assert property (nd && pac && pm3 == 8'h00 && pb |-> !dec_data.is_ac)
        else $error("ac decision after end of block");
    eob_zero_a: assert property (nd && pac && pm3 == 8'h00 && !pb |->
        dec_data.is_ac && dec_data.ctx == pc + 8'h01) else $error("eob not followed by zero test");
    zero_run_a: assert property (nd && pac && pm3 == 8'h01 && !pb |->
        dec_data.is_ac && dec_data.ctx == pc + 8'h03) else $error("zero run position skipped");
    zero_sign_a: assert property (nd && pac && pm3 == 8'h01 && pb |->
        dec_data.is_ac && dec_data.ctx == pc + 8'h01) else $error("ac sign context wrong");
    cover property (take && dec_data.op == ACDS_OP_FLUSH);
    cover property ((dec_valid && !dec_ready) [*3]);
    cover property (coef_valid && !coef_ready);
endmodule

// ==== sim/tb_acds_sequencer.sv ====
// Self-checking bench for the coefficient decision sequencer.
`timescale 1ns/1ps
module tb_acds_sequencer
    import acds_pkg::*;
;
    logic           sys_clk = 1'b0;
    logic           rstn = 1'b0;
    acds_coef_t     coef_data = '0;
    logic           coef_valid = 1'b0;
    logic           coef_ready;
    logic [3:0]     cond_lower = 4'h1;
    logic [3:0]     cond_upper = 4'h2;
    acds_decision_t dec_data;
    acds_decision_t taken;
    logic           dec_valid;
    logic           dec_ready;
    logic           take;
    logic [1:0]     mode = 2'h0;
    int             failures = 0;
    int             n_compared = 0;
    int             da[4];
    int             zz[64];
    int             c_ac;
    int             c_tb;
    acds_coef_t     wq[$];
    acds_decision_t eq[$];
    acds_decision_t rq[$];

    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (take) rq.push_back(taken);

    acds_sequencer DUT (.sys_clk(sys_clk), .rstn(rstn), .coef_data(coef_data),
        .coef_valid(coef_valid), .coef_ready(coef_ready), .cond_lower(cond_lower),
        .cond_upper(cond_upper), .dec_data(dec_data), .dec_valid(dec_valid),
        .dec_ready(dec_ready));
    acds_coder_model coder (.sys_clk(sys_clk), .rstn(rstn), .dec_data(dec_data),
        .dec_valid(dec_valid), .mode(mode), .dec_ready(dec_ready), .take(take),
        .taken(taken));

    task automatic end_of_test();
        if (failures == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic emit(input int b, input int ctx);
        eq.push_back(acds_decision_t'{ACDS_OP_DECIDE, b[0], c_ac[0], c_tb[1:0], ctx[7:0]});
    endtask

    task automatic code_v(input int v, input int ss, input int sp, input int sn, input int x1);
        int sz;
        int s;
        int m;
        sz = (v < 0 ? -v : v) - 1;
        s = v < 0 ? sn : sp;
        emit(v < 0, ss);
        emit(sz != 0, s);
        if (sz != 0) begin
            s = x1;
            m = 2;
            while (sz >= m) begin
                emit(1, s);
                m = m << 1;
                s++;
            end
            emit(0, s);
            for (m = m >> 2; m > 0; m = m >> 1) emit((sz & m) != 0, s + 14);
        end
    endtask

    function automatic int cls(input int d);
        int a;
        a = d < 0 ? -d : d;
        if (a <= (cond_lower == 4'h0 ? 0 : 1 << (cond_lower - 4'h1))) return 0;
        if (a <= (1 << cond_upper)) return d > 0 ? 4 : 8;
        return d > 0 ? 12 : 16;
    endfunction

    task automatic add_block(input int dt, input int at);
        int lnz;
        int k;
        lnz = 0;
        for (k = 1; k < 64; k++) if (zz[k] != 0) lnz = k;
        for (k = 0; k < 64; k++) begin
            wq.push_back(acds_coef_t'{ACDS_WORD_COEF, dt[1:0], at[1:0], lnz[5:0], zz[k][15:0]});
        end
        c_ac = 0;
        c_tb = dt;
        k = cls(da[dt]);
        emit(zz[0] != 0, k);
        if (zz[0] != 0) code_v(zz[0], k + 1, k + 2, k + 3, 20);
        da[dt] = zz[0];
        c_ac = 1;
        c_tb = at;
        k = 1;
        while (k < 64) begin
            emit(k > lnz, 3 * k - 3);
            if (k > lnz) break;
            for (; zz[k] == 0; k++) emit(0, 3 * k - 2);
            emit(1, 3 * k - 2);
            code_v(zz[k], 3 * k - 1, 3 * k - 1, 3 * k - 1, 190);
            k++;
        end
    endtask

    task automatic add_mark(input acds_word_kind_t kd, input acds_op_t op);
        wq.push_back(acds_coef_t'{kd, 2'h0, 2'h0, 6'h00, 16'h0000});
        eq.push_back(acds_decision_t'{op, 1'b0, 1'b0, 2'h0, 8'h00});
        if (kd == ACDS_WORD_START) da = '{0, 0, 0, 0};
        zz = '{default: 0};
    endtask

    task automatic send_word(input acds_coef_t w);
        coef_data  <= w;
        coef_valid <= 1'b1;
        @(posedge sys_clk);
        while (coef_ready !== 1'b1) @(posedge sys_clk);
    endtask

    task automatic run(input logic [1:0] md);
        int i;
        int g;
        i = 0;
        g = 0;
        mode <= md;
        if (md == 2'h2) begin
            while (i < wq.size()) begin
                coef_data  <= wq[i];
                coef_valid <= 1'b1;
                @(posedge sys_clk);
                if (coef_ready !== 1'b1) break;
                i++;
            end
            check(i >= 16 && i <= 18, 1);
            mode <= 2'h1;
        end
        for (; i < wq.size(); i++) send_word(wq[i]);
        coef_valid <= 1'b0;
        for (; rq.size() < eq.size() && g < 5000; g++) @(posedge sys_clk);
        repeat (20) @(posedge sys_clk);
        check(rq.size(), eq.size());
        for (i = 0; i < eq.size() && i < rq.size(); i++) begin
            if (eq[i].op != ACDS_OP_DECIDE) check(rq[i].op, eq[i].op);
            else check(rq[i], eq[i]);
        end
        wq.delete();
        eq.delete();
        rq.delete();
    endtask

    task automatic t_reset();
        check(dec_valid, 1'b0);
        repeat (2) @(posedge sys_clk);
        check(coef_ready, 1'b1);
    endtask

    task automatic t_zero();
        add_mark(ACDS_WORD_START, ACDS_OP_INIT);
        add_block(0, 3);
        add_block(1, 2);
        add_mark(ACDS_WORD_END, ACDS_OP_FLUSH);
        run(2'h0);
    endtask

    task automatic t_dc();
        int dv[8] = '{1, 3, -4, 5, -9, 0, 1000, -32767};
        add_mark(ACDS_WORD_START, ACDS_OP_INIT);
        foreach (dv[i]) begin
            zz[0] = dv[i];
            add_block(2, 1);
        end
        add_mark(ACDS_WORD_END, ACDS_OP_FLUSH);
        run(2'h1);
    endtask

    task automatic t_ac();
        // A zero lower bound turns a previous difference of one into a small one.
        cond_lower <= 4'h0;
        @(posedge sys_clk);
        add_mark(ACDS_WORD_START, ACDS_OP_INIT);
        zz[0] = -1;
        zz[1] = 1;
        zz[5] = -7;
        zz[20] = 300;
        zz[63] = 2;
        add_block(0, 0);
        zz = '{default: 0};
        zz[9] = 16383;
        zz[62] = -1;
        add_block(0, 1);
        zz[63] = -1;
        add_block(2, 2);
        zz = '{default: 0};
        zz[63] = 5;
        add_block(3, 3);
        add_mark(ACDS_WORD_END, ACDS_OP_FLUSH);
        run(2'h0);
    endtask

    task automatic t_fill();
        add_mark(ACDS_WORD_START, ACDS_OP_INIT);
        zz[0] = 7;
        zz[3] = -3;
        add_block(0, 1);
        add_mark(ACDS_WORD_END, ACDS_OP_FLUSH);
        run(2'h2);
    endtask

    initial begin
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        t_reset();
        t_zero();
        t_dc();
        t_ac();
        t_fill();
        end_of_test();
    end

    initial begin
        repeat (40000) @(posedge sys_clk);
        failures++;
        end_of_test();
    end
endmodule

bind acds_sequencer acds_seq_asserts chk (.sys_clk(sys_clk), .rstn(rstn),
    .coef_data(coef_data), .coef_valid(coef_valid), .coef_ready(coef_ready),
    .cond_lower(cond_lower), .cond_upper(cond_upper), .dec_data(dec_data),
    .dec_valid(dec_valid), .dec_ready(dec_ready));
